// [cfb_arith.v]
// Purpose: Combinational increment, double increment and invert
// Assumes: Byte form uses the low eight bits only
// Notes:   Flags other than N follow the original operand, not the sum
`timescale 1ns/10ps
`include "cfb_defs.vh"
module cfb_arith (
    // Operand
    input  wire [15:0] operand,
    input  wire        byte_mode,
    input  wire [3:0]  op,
    // Result
    output reg  [15:0] result,
    output reg         res_c,
    output reg         res_z,
    output reg         res_n,
    output reg         res_v
);
    reg [15:0] ones;
    reg [15:0] half;
    reg [15:0] masked;
    always @* begin
        ones   = byte_mode ? 16'h00ff : 16'hffff;
        half   = byte_mode ? 16'h007f : 16'h7fff;
        masked = operand & ones;
        result = masked;
        res_c  = 1'b0;
        res_z  = 1'b0;
        res_v  = 1'b0;
        case (op)
            `CFB_OP_INC: begin
                result = (masked + 16'h0001) & ones;
                res_c  = (masked == ones);
                res_z  = (masked == ones);
                res_v  = (masked == half);
            end
            `CFB_OP_INC2: begin
                result = (masked + 16'h0002) & ones;
                res_z  = (masked == (ones - 16'h0001));
                res_c  = (masked == ones) || (masked == (ones - 16'h0001));
                res_v  = (masked == half) || (masked == (half - 16'h0001));
            end
            default: begin
                result = masked ^ ones;
                res_z  = (masked == ones);
                res_c  = ~(masked == ones);
                res_v  = byte_mode ? masked[7] : masked[15];
            end
        endcase
        res_n = byte_mode ? result[7] : result[15];
    end
endmodule // cfb_arith

// [cfb_core.v]
// Purpose: Flag word, jump and interrupt enable handling for a subset of ops
// Assumes: One operation per op_valid cycle, issued by the core sequencer
// Notes:   Flag word layout and op codes live in cfb_defs.vh
//
// Contract
// - Disable clears enable bit via inverted mask
// - Disable leaves all other flag bits
// - Enable ORs mask, other bits kept
// - After enable, next instruction runs first
// - Increment sets carry, zero on all-ones
// - Increment overflow on largest positive value
// - Double increment zero on all-ones minus one
// - Double increment carry on top two values
// - Double increment overflow on top positives
// - Negative flag is result sign
// - Jump adds doubled sign-extended offset
// - Jump on carry when carry set
// - Jump on zero when zero set
// - Signed jump when negative equals overflow
// - Invert copies operand sign to overflow
// - Jumps change no flag or mode bit
`timescale 1ns/10ps
`include "cfb_defs.vh"
module cfb_core (
    // Clock and reset
    input  wire        clk,
    input  wire        rst,
    // Operation request
    input  wire        op_valid,
    input  wire [3:0]  op_code,
    input  wire        byte_mode,
    input  wire [15:0] operand,
    input  wire [9:0]  jump_offset,
    input  wire [19:0] next_pc_in,
    // Interrupt request from the core
    input  wire        irq_pending,
    // Results
    output reg  [15:0] flag_word,
    output reg  [19:0] program_counter,
    output reg  [15:0] result,
    output reg         result_valid,
    output reg         jump_taken,
    output reg         irq_accept,
    output reg         global_irq_enable,
    output reg         oscillator_off_bit,
    output reg         core_off_bit
);
    wire [15:0] alu_res;
    wire        alu_c;
    wire        alu_z;
    wire        alu_n;
    wire        alu_v;
    reg  [15:0] next_flag;
    reg         take;
    reg         is_alu;
    reg         hold_irq;
    wire [19:0] offset_ext;

    // Decoded operation strobes, qualified by op_valid
    reg         do_irq_dis;
    reg         do_irq_en;
    reg         do_inc;
    reg         do_inc2;
    reg         do_invert;
    reg         do_jmp_c;
    reg         do_jmp_z;
    reg         do_jmp_ge;
    reg         do_vclr;
    wire        do_alu;
    wire        do_jump;

    // Flag fields as they stand before this edge
    wire        carry_flag;
    wire        zero_flag;
    wire        negative_flag;
    wire        overflow_flag;
    wire        irq_enable_flag;
    // Next register values
    reg  [15:0] next_result;
    reg         next_result_valid;
    reg  [19:0] next_program_counter;
    reg         next_jump_taken;
    reg         next_hold_irq;
    reg         next_irq_accept;
    reg         next_global_irq_enable;
    reg         next_oscillator_off_bit;
    reg         next_core_off_bit;

    cfb_arith cfb_arith_inst (
        .operand   (operand),
        .byte_mode (byte_mode),
        .op        (op_code),
        .result    (alu_res),
        .res_c     (alu_c),
        .res_z     (alu_z),
        .res_n     (alu_n),
        .res_v     (alu_v)
    );

    // Offset doubled then sign extended to the full address width
    assign offset_ext = {{9{jump_offset[9]}}, jump_offset, 1'b0};

    // Operation decode; nothing fires without op_valid
    always @* begin
        do_irq_dis = 1'b0;
        do_irq_en  = 1'b0;
        do_inc     = 1'b0;
        do_inc2    = 1'b0;
        do_invert  = 1'b0;
        do_jmp_c   = 1'b0;
        do_jmp_z   = 1'b0;
        do_jmp_ge  = 1'b0;
        do_vclr    = 1'b0;
        if (op_valid) begin
            case (op_code)
                `CFB_OP_IRQ_DIS: do_irq_dis = 1'b1;
                `CFB_OP_IRQ_EN:  do_irq_en  = 1'b1;
                `CFB_OP_INC:     do_inc     = 1'b1;
                `CFB_OP_INC2:    do_inc2    = 1'b1;
                `CFB_OP_INVERT:  do_invert  = 1'b1;
                `CFB_OP_JMP_C:   do_jmp_c   = 1'b1;
                `CFB_OP_JMP_Z:   do_jmp_z   = 1'b1;
                `CFB_OP_JMP_GE:  do_jmp_ge  = 1'b1;
                `CFB_OP_VCLR:    do_vclr    = 1'b1;
                // Idle and unknown codes raise nothing but still move the counter
                default:         do_vclr    = 1'b0;
            endcase
        end
    end
    assign do_alu  = do_inc || do_inc2 || do_invert;
    assign do_jump = do_jmp_c || do_jmp_z || do_jmp_ge;

    // Flag fields as held in the flag word
    assign carry_flag      = flag_word[`CFB_BIT_C];
    assign zero_flag       = flag_word[`CFB_BIT_Z];
    assign negative_flag   = flag_word[`CFB_BIT_N];
    assign overflow_flag   = flag_word[`CFB_BIT_V];
    assign irq_enable_flag = flag_word[`CFB_BIT_IE];

    // Jump condition from the flags before this operation
    always @* begin
        take = 1'b0;
        if (do_jmp_c) begin
            take = carry_flag;
        end else if (do_jmp_z) begin
            take = zero_flag;
        end else if (do_jmp_ge) begin
            take = ~(negative_flag ^ overflow_flag);
        end
    end

    // Flag word update; jumps and unknown codes leave it alone
    always @* begin
        next_flag = flag_word;
        is_alu    = do_alu;
        if (do_irq_dis) begin
            next_flag = flag_word & ~`CFB_IE_MASK;
        end else if (do_irq_en) begin
            next_flag = flag_word | `CFB_IE_MASK;
        end else if (do_alu) begin
            next_flag[`CFB_BIT_C] = alu_c;
            next_flag[`CFB_BIT_Z] = alu_z;
            next_flag[`CFB_BIT_N] = alu_n;
            next_flag[`CFB_BIT_V] = alu_v;
        end else if (do_vclr) begin
            next_flag[`CFB_BIT_V] = 1'b0;
        end
    end

    // Mode bits mirror the word they will hold after this edge
    always @* begin
        next_global_irq_enable  = next_flag[`CFB_BIT_IE];
        next_oscillator_off_bit = next_flag[`CFB_BIT_OSC];
        next_core_off_bit       = next_flag[`CFB_BIT_CORE];
    end

    // Result word and its one-cycle strobe
    always @* begin
        next_result       = result;
        next_result_valid = is_alu;
        if (is_alu) begin
            next_result = alu_res;
        end
    end

    // Program counter follows every accepted operation
    always @* begin
        next_program_counter = program_counter;
        next_jump_taken      = do_jump && take;
        if (op_valid) begin
            if (take) begin
                // Taken jump is relative to the following instruction
                next_program_counter = next_pc_in + offset_ext;
            end else begin
                next_program_counter = next_pc_in;
            end
        end
    end

    // Enable holds off service until one more instruction retires
    always @* begin
        next_hold_irq = hold_irq;
        if (do_irq_en) begin
            next_hold_irq = 1'b1;
        end else if (op_valid) begin
            next_hold_irq = 1'b0;
        end
    end

    // Disable acts from the next edge, so one more accept can slip through
    always @* begin
        next_irq_accept = 1'b0;
        if (irq_pending && irq_enable_flag) begin
            if (!hold_irq && !do_irq_en) begin
                next_irq_accept = 1'b1;
            end
        end
    end

    // Registered outputs, one flop group each
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_word <= `CFB_FLAG_RESET;
        end else begin
            flag_word <= next_flag;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            global_irq_enable <= 1'b0;
        end else begin
            global_irq_enable <= next_global_irq_enable;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            oscillator_off_bit <= 1'b0;
        end else begin
            oscillator_off_bit <= next_oscillator_off_bit;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            core_off_bit <= 1'b0;
        end else begin
            core_off_bit <= next_core_off_bit;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            result <= 16'h0000;
        end else begin
            result <= next_result;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            result_valid <= 1'b0;
        end else begin
            result_valid <= next_result_valid;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            program_counter <= `CFB_PROG_CNT_RESET;
        end else begin
            program_counter <= next_program_counter;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            jump_taken <= 1'b0;
        end else begin
            jump_taken <= next_jump_taken;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_irq <= 1'b0;
        end else begin
            hold_irq <= next_hold_irq;
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_accept <= 1'b0;
        end else begin
            irq_accept <= next_irq_accept;
        end
    end
endmodule // cfb_core

// [cfb_core_bench.sv]
// Purpose: Self-checking bench for cfb_core
// Assumes: Outputs settle one cycle after an op
// Notes:   Expected flags rebuilt from the operand, never read back
`timescale 1ns/10ps
module cfb_core_bench;
    logic        clk = 0, rst = 1, op_valid = 0, byte_mode = 0, irq_pending = 0;
    logic [3:0]  op_code = 0;
    logic [15:0] operand = 0, flag_word, result;
    logic [9:0]  jump_offset = 0;
    logic [19:0] next_pc_in = 20'h00400, program_counter, e;
    logic        result_valid, jump_taken, irq_accept, global_irq_enable, oscillator_off_bit, core_off_bit, t;
    int          n_fail = 0, comparisons = 0, cyc = 0;
    always #5 clk = ~clk;
    cfb_core cfb_core_inst (.clk, .rst, .op_valid, .op_code, .byte_mode, .operand, .jump_offset, .next_pc_in,
        .irq_pending, .flag_word, .program_counter, .result, .result_valid, .jump_taken, .irq_accept,
        .global_irq_enable, .oscillator_off_bit, .core_off_bit);
    task chk(input logic [19:0] got, want);
        comparisons++;
        if (got !== want) begin
            n_fail++;
            $display("unexpected at %0t: %h not %h", $time, got, want);
        end
    endtask
    task wrap_up;
        if (n_fail == 0 && comparisons > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Idle cycle after each op keeps drive and check apart
    task run(input logic [3:0] c, input logic b, input logic [15:0] d);
        @(posedge clk);
        op_valid <= 1;
        op_code <= c;
        byte_mode <= b;
        operand <= d;
        @(posedge clk);
        op_valid <= 0;
        #1;
    endtask
    function logic [19:0] ex(input logic [3:0] c, input logic b, input logic [15:0] d);
        logic [15:0] m, h, x, r;
        logic        cf, zf, vf;
        m = b ? 16'h00ff : 16'hffff;
        h = m ^ (m >> 1);
        x = d & m;
        r = (c == 5 ? ~x : x + (c == 4 ? 16'd2 : 16'd1)) & m;
        zf = x == m - (c == 4);
        cf = c == 5 ? !zf : x >= m - (c == 4);
        vf = c == 5 ? |(x & h) : (x == h - 1 || (c == 4 && x == h - 2));
        return {r, vf, |(r & h), zf, cf};
    endfunction
    task t_arith;
        logic [15:0] v [8] = '{16'hffff, 16'hfffe, 16'h7fff, 16'h7ffe, 16'h807f, 16'h017e, 16'h00ff, 16'h0000};
        for (int c = 3; c < 6; c++)
            for (int b = 0; b < 2; b++)
                foreach (v[i]) begin
                    run(4'(c), b[0], v[i]);
                    chk({result, flag_word[8], flag_word[2:0]}, ex(4'(c), b[0], v[i]));
                    chk({19'h0, result_valid}, 20'h1);
                end
    endtask
    task t_irq;
        run(4'h3, 0, 16'h7fff);
        @(posedge clk);
        irq_pending <= 1;
        run(4'h2, 0, 0);
        chk({4'h0, flag_word}, 20'h0010c);
        chk({19'h0, global_irq_enable}, 20'h1);
        chk({19'h0, irq_accept}, 20'h0);
        run(4'ha, 0, 0);
        chk({19'h0, irq_accept}, 20'h0);
        @(posedge clk);
        #1;
        chk({19'h0, irq_accept}, 20'h1);
        run(4'h1, 0, 0);
        chk({4'h0, flag_word}, 20'h00104);
        chk({17'h0, global_irq_enable, oscillator_off_bit, core_off_bit}, 20'h0);
        chk({19'h0, irq_accept}, 20'h1);
        run(4'ha, 0, 0);
        chk({19'h0, irq_accept}, 20'h0);
        @(posedge clk);
        irq_pending <= 0;
    endtask
    task t_jump;
        logic [15:0] p [4] = '{16'hffff, 16'h0000, 16'h0000, 16'h7fff};
        logic [3:0]  q [4] = '{4'h3, 4'h3, 4'h5, 4'h4};
        for (int j = 6; j < 9; j++)
            foreach (p[i]) begin
                run(q[i], 0, p[i]);
                e = ex(q[i], 0, p[i]);
                t = j == 6 ? e[0] : j == 7 ? e[1] : e[2] == e[3];
                @(posedge clk);
                jump_offset <= j == 8 ? 10'h200 : 10'h1ff;
                run(4'(j), 0, 0);
                chk(program_counter, t ? (j == 8 ? 20'h00000 : 20'h007fe) : 20'h00400);
                chk({19'h0, jump_taken}, {19'h0, t});
                chk({16'h0, flag_word[8], flag_word[2:0]}, {16'h0, e[3:0]});
                chk({18'h0, result_valid, flag_word[3]}, 20'h0);
            end
    endtask
    task t_vclr;
        run(4'h3, 0, 16'h7fff);
        run(4'h9, 0, 0);
        chk({19'h0, flag_word[8]}, 20'h0);
        run(4'h8, 0, 0);
        chk({19'h0, jump_taken}, 20'h0);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst <= 0;
        t_arith;
        t_irq;
        t_jump;
        t_vclr;
        wrap_up;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_fail++;
            wrap_up;
        end
    end
endmodule // cfb_core_bench

// [cfb_core_chk.sv]
// Purpose: Checker for cfb_core flag, jump and enable behaviour
// Assumes: One clock domain, async high reset
// Notes:   Sees top ports only, attached by bind
`timescale 1ns/10ps
module cfb_core_chk (
    // Clock and reset
    input logic        clk,
    input logic        rst,
    // Operation request
    input logic        op_valid,
    input logic [3:0]  op_code,
    input logic        byte_mode,
    input logic [15:0] operand,
    input logic [9:0]  jump_offset,
    input logic [19:0] next_pc_in,
    // Observed results
    input logic [15:0] flag_word,
    input logic [19:0] program_counter,
    input logic        jump_taken,
    input logic        irq_accept
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    logic [19:0] tgt;
    logic        all1, take, jmp;
    assign all1 = byte_mode ? operand[7:0] == 8'hff : operand == 16'hffff;
    assign tgt = next_pc_in + {{9{jump_offset[9]}}, jump_offset, 1'b0};
    assign take = op_code == 4'h6 ? flag_word[0] : op_code == 4'h7 ? flag_word[1] : flag_word[2] == flag_word[8];
    assign jmp = op_valid && op_code >= 4'h6 && op_code <= 4'h8;
    a_dis_clears_ie: assert property (op_valid && op_code == 4'h1 |=>
        flag_word == ($past(flag_word) & ~16'h0008)) else $error("disable altered flags");
    a_en_sets_ie: assert property (op_valid && op_code == 4'h2 |=>
        flag_word == ($past(flag_word) | 16'h0008)) else $error("enable altered flags");
    a_en_defers_irq: assert property (op_valid && op_code == 4'h2 |=> !irq_accept)
        else $error("irq accepted after enable");
    a_inc_carry_zero: assert property (op_valid && op_code == 4'h3 |=>
        flag_word[0] == $past(all1) && flag_word[1] == $past(all1)) else $error("inc carry zero");
    a_inv_carry: assert property (op_valid && op_code == 4'h5 |=> flag_word[0] == !flag_word[1])
        else $error("invert carry not inverse of zero");
    a_vclr_clears_v: assert property (op_valid && op_code == 4'h9 |=> !flag_word[8])
        else $error("overflow not cleared");
    a_jump_cond: assert property (jmp |=> jump_taken == $past(take))
        else $error("jump decision");
    a_jump_target: assert property (jmp |=>
        program_counter == (jump_taken ? $past(tgt) : $past(next_pc_in))) else $error("jump target");
    a_jump_flags: assert property (jmp |=> flag_word == $past(flag_word))
        else $error("jump changed flags");
    cover property (jump_taken);
    cover property (irq_accept);
    cover property (op_valid && byte_mode);
endmodule // cfb_core_chk
bind cfb_core cfb_core_chk cfb_core_chk_inst (
    .clk             (clk),
    .rst             (rst),
    .op_valid        (op_valid),
    .op_code         (op_code),
    .byte_mode       (byte_mode),
    .operand         (operand),
    .jump_offset     (jump_offset),
    .next_pc_in      (next_pc_in),
    .flag_word       (flag_word),
    .program_counter (program_counter),
    .jump_taken      (jump_taken),
    .irq_accept      (irq_accept)
);

// [cfb_defs.vh]
// Purpose: Constants for the flag and branch execution block
// Assumes: Flag word layout C=0 Z=1 N=2 IE=3 OSC=5 CORE=4 V=8
// Notes:   Offsets of flag bits, masks and operation codes
`ifndef CFB_DEFS_VH
`define CFB_DEFS_VH

`define CFB_BIT_C        0
`define CFB_BIT_Z        1
`define CFB_BIT_N        2
`define CFB_BIT_IE       3
`define CFB_BIT_CORE     4
`define CFB_BIT_OSC      5
`define CFB_BIT_V        8
`define CFB_IE_MASK      16'h0008
`define CFB_FLAG_RESET   16'h0000
`define CFB_PROG_CNT_RESET 20'h00000

`define CFB_OP_NONE      4'h0
`define CFB_OP_IRQ_DIS   4'h1
`define CFB_OP_IRQ_EN    4'h2
`define CFB_OP_INC       4'h3
`define CFB_OP_INC2      4'h4
`define CFB_OP_INVERT    4'h5
`define CFB_OP_JMP_C     4'h6
`define CFB_OP_JMP_Z     4'h7
`define CFB_OP_JMP_GE    4'h8
`define CFB_OP_VCLR      4'h9
`define CFB_OP_IDLE      4'ha

`endif
